// ===== bench/ace_analog_model.sv
module ace_analog_model #(
    parameter logic [11:0] REF_MV = 12'h4c4
) (
    input wire logic        power_off_i,
    input wire logic        ref_internal_i,
    input wire logic [11:0] pos_mv_i,
    input wire logic [11:0] neg_mv_i,
    output logic            raw_o
);
    // unpowered comparator gives no valid answer; low is the design's own forced level
    assign raw_o = !power_off_i && ((ref_internal_i ? REF_MV : pos_mv_i) > neg_mv_i);
endmodule // ace_analog_model

// ===== bench/ace_assertions.sv
module ace_assertions (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        brownout_detect_fuse_i,
    input wire logic        global_irq_enable_i,
    input wire logic        vector_ack_i,
    input wire logic        comparator_power_off_o,
    input wire logic        ref_select_internal_o,
    input wire logic        capture_trigger_o,
    input wire logic        comparator_irq_o
);
    logic wr0;
    assign wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    a_irq_gated: assert property (comparator_irq_o |-> $past(global_irq_enable_i) && !$past(vector_ack_i))
        else $error("comparator irq without enable");
    a_ack_clears: assert property (vector_ack_i |=> !comparator_irq_o)
        else $error("vector ack left irq up");
    a_flag_w1c: assert property (wr0 && avs_writedata_i[4] |-> ##2 !comparator_irq_o)
        else $error("flag clear ignored");
    a_power_write: assert property (wr0 |-> ##2 comparator_power_off_o == $past(avs_writedata_i[7], 2))
        else $error("power off bit not applied");
    a_ref_gate: assert property (ref_select_internal_o && $stable(brownout_detect_fuse_i) |-> brownout_detect_fuse_i)
        else $error("reference without fuse");
    a_capture_off: assert property (wr0 && !avs_writedata_i[2] |-> ##2 !capture_trigger_o)
        else $error("capture still routed");
    a_wait_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("no answer after one wait");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule // ace_assertions

// ===== bench/test_comparator_event_control.sv
module test_comparator_event_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd_s = 1'b0, wr_s = 1'b0, fuse = 1'b0, gie = 1'b0, ack = 1'b0;
    logic [31:0] wdat = 32'h0, rdat, v;
    logic        wreq, raw, pwr, refi, cap, cirq, irq;
    logic [11:0] pos = 12'h0, neg = 12'h100;
    int          failures = 0, n_checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    ace_comparator_event uut (.mclk_i, .rst_n_i, .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .comparator_raw_i(raw), .brownout_detect_fuse_i(fuse), .global_irq_enable_i(gie), .vector_ack_i(ack),
        .comparator_power_off_o(pwr), .ref_select_internal_o(refi), .capture_trigger_o(cap),
        .comparator_irq_o(cirq), .irq_o(irq));
    ace_analog_model amod (.power_off_i(pwr), .ref_internal_i(refi), .pos_mv_i(pos), .neg_mv_i(neg), .raw_o(raw));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_i);
        adr <= a;
        wdat <= d;
        rd_s <= !w;
        wr_s <= w;
        // pre-update values here are exactly what the edge sampled
        do begin
            @(posedge mclk_i);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        if (k == 20) begin
            failures++;
            close_out();
        end
        v = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask
    function automatic logic hit(input logic [1:0] m, input logic up);
        return m == 2'h0 || (m == 2'h3 && up) || (m == 2'h2 && !up);
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] m;
        logic       up;
        v = $urandom(62);
        cyc(3);
        rst_n_i <= 1'b1;
        bus(0, 4'h0, 0);
        chk("ctrl_rst", v, 32'h0);
        bus(1, 4'hc, 32'hff);
        bus(0, 4'hc, 0);
        chk("unmapped", v, 32'h0);
        bus(1, 4'h8, 32'h1);
        gie <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            m = 2'(i >> 1);
            up = !i[0];
            bus(1, 4'h0, 32'(m));
            bus(1, 4'h0, 32'h18 | m);
            bus(1, 4'h4, 32'h1);
            pos <= up ? neg + 12'h1 + 12'($urandom % 500) : neg - 12'h1 - 12'($urandom % 200);
            cyc(6);
            bus(0, 4'h0, 0);
            chk("level", v[5], up);
            chk("flag", v[4], hit(m, up));
            chk("cmp_irq", cirq, hit(m, up));
            chk("irq", irq, hit(m, up));
            bus(1, 4'h0, 32'h08 | m);
            bus(0, 4'h0, 0);
            chk("keep", v[4], hit(m, up));
        end
        bus(1, 4'h0, 32'h18);
        gie <= 1'b0;
        pos <= 12'hfff;
        cyc(6);
        chk("gie_off", cirq, 1'b0);
        bus(1, 4'h8, 32'h0);
        gie <= 1'b1;
        cyc(3);
        chk("masked", {cirq, irq}, 2'b10);
        @(posedge mclk_i) ack <= 1'b1;
        @(posedge mclk_i) ack <= 1'b0;
        bus(0, 4'h0, 0);
        chk("vec_clr", {v[4], cirq}, 2'b00);
        fuse <= 1'b1;
        pos <= 12'h0;
        neg <= 12'($urandom % 1000);
        bus(1, 4'h0, 32'h40);
        cyc(6);
        bus(0, 4'h0, 0);
        chk("ref_on", {refi, v[5]}, 2'b11);
        fuse <= 1'b0;
        cyc(6);
        bus(0, 4'h0, 0);
        chk("ref_fuse", {refi, v[5]}, 2'b00);
        pos <= 12'hfff;
        bus(1, 4'h0, 32'h04);
        cyc(6);
        chk("cap_on", cap, 1'b1);
        bus(1, 4'h0, 32'h00);
        cyc(3);
        chk("cap_off", cap, 1'b0);
        bus(1, 4'h0, 32'h80);
        cyc(6);
        bus(0, 4'h0, 0);
        chk("pwr_off", {pwr, v[5]}, 2'b10);
        close_out();
    end
endmodule // test_comparator_event_control

bind ace_comparator_event ace_assertions chk_i (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .brownout_detect_fuse_i, .global_irq_enable_i,
    .vector_ack_i, .comparator_power_off_o, .ref_select_internal_o, .capture_trigger_o, .comparator_irq_o);

// ===== common/ace_defines.svh
`ifndef ACE_DEFINES_SVH
`define ACE_DEFINES_SVH

// register byte addresses
`define ACE_ADDR_CTRL_STATUS 4'h0
`define ACE_ADDR_IRQ_STATUS  4'h4
`define ACE_ADDR_IRQ_MASK    4'h8

// control/status field positions
`define ACE_BIT_POWER_OFF    7
`define ACE_BIT_REF_SELECT   6
`define ACE_BIT_OUTPUT_LEVEL 5
`define ACE_BIT_EVENT_FLAG   4
`define ACE_BIT_IRQ_ENABLE   3
`define ACE_BIT_CAPTURE      2

// reset values
`define ACE_CTRL_RESET       8'h00
`define ACE_MASK_RESET       8'h00
`define ACE_UNMAPPED_READ    32'h0000_0000

`endif

// ===== common/ace_pkg.sv
package ace_pkg;

    typedef enum logic [1:0] {
        ACE_MODE_TOGGLE   = 2'h0,
        ACE_MODE_RESERVED = 2'h1,
        ACE_MODE_FALLING  = 2'h2,
        ACE_MODE_RISING   = 2'h3
    } ace_mode_t;

    typedef struct packed {
        logic      power_off;
        logic      ref_select;
        logic      irq_enable;
        logic      capture_route;
        ace_mode_t mode;
    } ace_ctrl_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ace_bus_req_t;

    // bus answer fsm, gray coded along idle -> answer
    typedef enum logic [0:0] {
        ACE_BUS_IDLE   = 1'b0,
        ACE_BUS_ANSWER = 1'b1
    } ace_bus_state_t;

endpackage

// ===== design/ace_comparator_event.sv
// Overview of operation
// - status bit follows comparator, one when positive input exceeds negative input.
// - power-off bit set removes comparator power; writable any time.
// - reference select with brown-out fuse feeds fixed reference; else positive pin.
// - event flag sets on the edge or toggle chosen by mode field.
// - interrupt requested only when flag, irq enable and global enable are one; irq_o ignores all three and comes from irq status and mask alone.
// - flag clears automatically when processor executes comparator vector.
// - writing one to flag bit clears it; zero leaves it.
// - capture route bit connects comparator output to timer capture front end.
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`include "ace_defines.svh"

module ace_comparator_event (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        comparator_raw_i,
    input  wire logic        brownout_detect_fuse_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        vector_ack_i,
    output logic             comparator_power_off_o,
    output logic             ref_select_internal_o,
    output logic             capture_trigger_o,
    output logic             comparator_irq_o,
    output logic             irq_o
);

    ace_pkg::ace_ctrl_t      ctrl_reg;
    ace_pkg::ace_bus_req_t   req;
    ace_pkg::ace_bus_state_t bus_state_reg;
    logic       sync1_reg;
    logic       sync2_reg;
    logic       prev_reg;
    logic       event_flag_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic       event_hit;
    logic       wr_take;
    logic       rd_take;

    function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic logic mode_hit(input ace_pkg::ace_mode_t m, input logic cur, input logic prv);
        unique case (m)
            ace_pkg::ACE_MODE_TOGGLE:   return cur != prv;
            ace_pkg::ACE_MODE_RESERVED: return 1'b0;
            ace_pkg::ACE_MODE_FALLING:  return prv & ~cur;
            ace_pkg::ACE_MODE_RISING:   return cur & ~prv;
        endcase
    endfunction

    assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                   writedata: avs_writedata_i, byteenable: avs_byteenable_i};

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then an answer cycle with waitrequest low

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state_reg <= ace_pkg::ACE_BUS_IDLE;
        end else if (bus_state_reg == ace_pkg::ACE_BUS_ANSWER) begin
            bus_state_reg <= ace_pkg::ACE_BUS_IDLE;
        end else if (req.read || req.write) begin
            bus_state_reg <= ace_pkg::ACE_BUS_ANSWER;
        end
    end

    // waitrequest is high at rest; it drops only for the answer cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((bus_state_reg == ace_pkg::ACE_BUS_IDLE) && (req.read || req.write));
        end
    end

    assign wr_take = req.write && !avs_waitrequest_o && req.byteenable[0];
    assign rd_take = req.read && (bus_state_reg == ace_pkg::ACE_BUS_IDLE);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= `ACE_UNMAPPED_READ;
        end else if (rd_take) begin
            if (sel(req.address, `ACE_ADDR_CTRL_STATUS)) begin
                avs_readdata_o <= {24'h000000, ctrl_reg.power_off, ctrl_reg.ref_select,
                                   sync2_reg, event_flag_reg, ctrl_reg.irq_enable,
                                   ctrl_reg.capture_route, ctrl_reg.mode};
            end else if (sel(req.address, `ACE_ADDR_IRQ_STATUS)) begin
                avs_readdata_o <= {24'h000000, irq_status_reg};
            end else if (sel(req.address, `ACE_ADDR_IRQ_MASK)) begin
                avs_readdata_o <= {24'h000000, irq_mask_reg};
            end else begin
                avs_readdata_o <= `ACE_UNMAPPED_READ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= ace_pkg::ace_ctrl_t'(6'h00);
        end else if (wr_take && sel(req.address, `ACE_ADDR_CTRL_STATUS)) begin
            ctrl_reg.power_off     <= req.writedata[`ACE_BIT_POWER_OFF];
            ctrl_reg.ref_select    <= req.writedata[`ACE_BIT_REF_SELECT];
            ctrl_reg.irq_enable    <= req.writedata[`ACE_BIT_IRQ_ENABLE];
            ctrl_reg.capture_route <= req.writedata[`ACE_BIT_CAPTURE];
            ctrl_reg.mode          <= ace_pkg::ace_mode_t'(req.writedata[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparator sampling and event detection

    // the first stage feeds only the second: the raw level may be metastable
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= comparator_raw_i & ~ctrl_reg.power_off;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign event_hit = mode_hit(ctrl_reg.mode, sync2_reg, prev_reg);

    // a new event in the clearing cycle wins, so none is lost
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_flag_reg <= 1'b0;
        end else if (event_hit) begin
            event_flag_reg <= 1'b1;
        end else if (vector_ack_i) begin
            event_flag_reg <= 1'b0;
        end else if (wr_take && sel(req.address, `ACE_ADDR_CTRL_STATUS)
                     && req.writedata[`ACE_BIT_EVENT_FLAG]) begin
            event_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system interrupt status and mask (bit 0: comparator event)

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_reg <= 8'h00;
        end else begin
            irq_status_reg <= (irq_status_reg & ~((wr_take && sel(req.address, `ACE_ADDR_IRQ_STATUS))
                              ? req.writedata[7:0] : 8'h00)) | {7'h00, event_hit};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask_reg <= `ACE_MASK_RESET;
        end else if (wr_take && sel(req.address, `ACE_ADDR_IRQ_MASK)) begin
            irq_mask_reg <= req.writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            comparator_power_off_o <= 1'b0;
            ref_select_internal_o  <= 1'b0;
            capture_trigger_o      <= 1'b0;
            comparator_irq_o       <= 1'b0;
            irq_o                  <= 1'b0;
        end else begin
            comparator_power_off_o <= ctrl_reg.power_off;
            ref_select_internal_o  <= ctrl_reg.ref_select & brownout_detect_fuse_i;
            // capture filtering and edge choice stay in the timer front end
            capture_trigger_o      <= ctrl_reg.capture_route & sync2_reg;
            comparator_irq_o       <= event_flag_reg & ctrl_reg.irq_enable
                                      & global_irq_enable_i & ~vector_ack_i;
            irq_o                  <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule // ace_comparator_event
